/* scrcs_pkg.sv */
// constants, types and helpers of the s-curve range and correction speed block
// assumes a single 10 mhz clock and a plain word-indexed register port
package scrcs_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SPAN_W = 16;
  localparam int unsigned SPEED_W = 17;
  localparam int unsigned AMT_W = 24;
  localparam int unsigned RATE_W = 16;
  localparam int unsigned MULT_W = 12;
  localparam int unsigned PROD_W = 42;

  // ---------------------------------------------------------------
  // limits and reset values
  // ---------------------------------------------------------------
  localparam logic [SPAN_W-1:0] SPAN_MAX = 16'hc350;
  localparam logic [SPEED_W-1:0] FEED_MAX = 17'h186a0;
  localparam logic [SPEED_W-1:0] BAND_MIN = 17'h00001;
  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_ACCEL_SPAN = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_DECEL_SPAN = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_FEED_SPEED = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_TOP_SPEED = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_START_SPEED = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_UP_RATE = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_DOWN_RATE = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_MULT_CODE = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_AMOUNT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_MODE = 5'h09;
  localparam logic [ADDR_W-1:0] OFS_BACKLASH = 5'h0a;
  localparam logic [ADDR_W-1:0] OFS_COMMAND = 5'h0b;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_CUR_SPEED = 5'h0d;
  localparam logic [ADDR_W-1:0] OFS_REMAINING = 5'h0e;
  localparam logic [ADDR_W-1:0] OFS_APPLIED_TOP = 5'h0f;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned MODE_SHAPE_BIT = 0;
  localparam int unsigned MODE_ADJ_OFF_BIT = 1;
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_DIR_BIT = 1;
  localparam int unsigned CMD_CORR_BIT = 2;
  localparam int unsigned CMD_ORIGIN_BIT = 3;
  localparam int unsigned CMD_STOP_BIT = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACCEL = 3'b001,
    ST_CONST = 3'b010,
    ST_DECEL = 3'b011,
    ST_CORRECT = 3'b100,
    ST_REVERSE = 3'b101
  } scrcs_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [SPAN_W-1:0] clamp_span(input logic [SPAN_W-1:0] v);
    clamp_span = (v > SPAN_MAX) ? SPAN_MAX : v;
  endfunction

  // width of one s band in speed units; linear ramps use the minimum band
  function automatic logic [SPEED_W-1:0] band_of(input logic [SPAN_W-1:0] span,
      input logic [SPEED_W-1:0] top, input logic [SPEED_W-1:0] start, input logic shape);
    logic [SPEED_W-1:0] h;
    h = BAND_MIN;
    if (shape) begin
      if (clamp_span(span) == '0) begin
        h = (top > start) ? ((top - start) >> 1) : '0;
      end else begin
        h = {1'b0, clamp_span(span)};
      end
    end
    band_of = (h == '0) ? BAND_MIN : h;
  endfunction

  // step weight: grows with distance from the nearer band edge
  function automatic logic [SPEED_W-1:0] step_add(input logic [SPEED_W-1:0] lo,
      input logic [SPEED_W-1:0] hi, input logic [SPEED_W-1:0] band);
    logic [SPEED_W-1:0] m;
    m = (lo < hi) ? lo : hi;
    step_add = (m >= band) ? band : m + BAND_MIN;
  endfunction

endpackage

/* scrcs_pulse_gen.sv */
// phase accumulator turning a speed value into a pulse train
// assumes en is a one-cycle tick from the speed multiplier divider
`timescale 1ns/10ps
module scrcs_pulse_gen #(
  parameter int unsigned ACC_W = 18
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic en,
  input wire logic run,
  input wire logic [scrcs_pkg::SPEED_W-1:0] speed,
  output logic pulse
);
  import scrcs_pkg::*;

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W:0] sum;

  assign sum = {1'b0, acc_q} + {{(ACC_W+1-SPEED_W){1'b0}}, speed};

  // output rate is speed times base tick rate over two to the acc_w
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      acc_q <= '0;
      pulse <= 1'b0;
    end else begin
      pulse <= en & sum[ACC_W];
      if (en) begin
        acc_q <= sum[ACC_W-1:0];
      end
    end
  end

endmodule

/* scrcs_axis_profile.sv */
// speed profile core of one pulse-train axis: s-curve bands, correction feed,
// and automatic lowering of top speed on short moves
// assumes registers are reached over a plain strobe port, read data one cycle later
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
//
// Function
// - accel span takes 1..50000; larger writes act as 50000.
// - accel is s-shaped within span*mult of start and top, linear between.
// - accel span zero means half of top minus start: pure s-curve.
// - decel span takes 1..50000; larger writes act as 50000.
// - decel is s-shaped within span*mult of both speeds, linear between.
// - decel span zero means half of top minus start: pure s-curve.
// - correction feed speed takes 1..100000; larger writes act as 100000.
// - backlash correction pulses at feed speed times multiplier.
// - origin return reversal also runs at the correction feed speed.
// - with correction bit 0, short moves lower top speed to avoid triangles.
// - ramp shape bit 0 selects linear, 1 selects s-curve ramps.
module scrcs_axis_profile #(
  parameter int unsigned ACC_W = 18
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [scrcs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [scrcs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [scrcs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic origin_sensor,
  output logic pulse_out,
  output logic dir_out,
  output logic busy
);
  import scrcs_pkg::*;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [SPAN_W-1:0] accel_span_q;
  logic [SPAN_W-1:0] decel_span_q;
  logic [SPEED_W-1:0] feed_speed_q;
  logic [SPEED_W-1:0] top_speed_q;
  logic [SPEED_W-1:0] start_speed_q;
  logic [RATE_W-1:0] up_rate_q;
  logic [RATE_W-1:0] down_rate_q;
  logic [MULT_W-1:0] mult_code_q;
  logic [AMT_W-1:0] amount_q;
  logic ramp_shape_select_q;
  logic auto_top_speed_correction_off_q;
  logic [SPAN_W-1:0] backlash_q;
  logic cmd_start;
  logic cmd_dir;
  logic cmd_corr;
  logic cmd_origin;
  logic cmd_stop;

  // stored as written; the clamps act at the point of use
  always_ff @(posedge clk) begin
    if (reset) begin
      accel_span_q <= REG_RESET[SPAN_W-1:0];
      decel_span_q <= REG_RESET[SPAN_W-1:0];
      feed_speed_q <= REG_RESET[SPEED_W-1:0];
      top_speed_q <= REG_RESET[SPEED_W-1:0];
      start_speed_q <= REG_RESET[SPEED_W-1:0];
      up_rate_q <= REG_RESET[RATE_W-1:0];
      down_rate_q <= REG_RESET[RATE_W-1:0];
      mult_code_q <= REG_RESET[MULT_W-1:0];
      amount_q <= REG_RESET[AMT_W-1:0];
      ramp_shape_select_q <= 1'b0;
      auto_top_speed_correction_off_q <= 1'b0;
      backlash_q <= REG_RESET[SPAN_W-1:0];
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_ACCEL_SPAN: accel_span_q <= reg_wdata[SPAN_W-1:0];
        OFS_DECEL_SPAN: decel_span_q <= reg_wdata[SPAN_W-1:0];
        OFS_FEED_SPEED: feed_speed_q <= reg_wdata[SPEED_W-1:0];
        OFS_TOP_SPEED: top_speed_q <= reg_wdata[SPEED_W-1:0];
        OFS_START_SPEED: start_speed_q <= reg_wdata[SPEED_W-1:0];
        OFS_UP_RATE: up_rate_q <= reg_wdata[RATE_W-1:0];
        OFS_DOWN_RATE: down_rate_q <= reg_wdata[RATE_W-1:0];
        OFS_MULT_CODE: mult_code_q <= reg_wdata[MULT_W-1:0];
        OFS_AMOUNT: amount_q <= reg_wdata[AMT_W-1:0];
        OFS_MODE: begin
          ramp_shape_select_q <= reg_wdata[MODE_SHAPE_BIT];
          auto_top_speed_correction_off_q <= reg_wdata[MODE_ADJ_OFF_BIT];
        end
        OFS_BACKLASH: backlash_q <= reg_wdata[SPAN_W-1:0];
        default: ;
      endcase
    end
  end

  assign cmd_start = reg_wr && (reg_addr == OFS_COMMAND) && reg_wdata[CMD_START_BIT];
  assign cmd_dir = reg_wdata[CMD_DIR_BIT];
  assign cmd_corr = reg_wr && (reg_addr == OFS_COMMAND) && reg_wdata[CMD_CORR_BIT];
  assign cmd_origin = reg_wr && (reg_addr == OFS_COMMAND) && reg_wdata[CMD_ORIGIN_BIT];
  assign cmd_stop = reg_wr && (reg_addr == OFS_COMMAND) && reg_wdata[CMD_STOP_BIT];

  // ---------------------------------------------------------------
  // motion state
  // ---------------------------------------------------------------
  scrcs_state_t state_q;
  logic [SPEED_W-1:0] speed_q;
  logic [SPEED_W-1:0] applied_top_q;
  logic [AMT_W-1:0] remaining_q;
  logic [AMT_W-1:0] accel_pulses_q;
  logic [SPAN_W-1:0] corr_cnt_q;
  logic pending_move_q;
  logic last_dir_q;
  logic [SPEED_W:0] step_acc_q;
  logic [MULT_W-1:0] base_cnt_q;
  logic [RATE_W-1:0] rate_cnt_q;
  logic base_tick;
  logic step_tick;
  logic pulse_raw;
  logic running;
  logic [SPEED_W-1:0] feed_eff;
  logic [SPEED_W-1:0] band_up;
  logic [SPEED_W-1:0] band_dn;
  logic [SPEED_W-1:0] band;
  logic [SPEED_W-1:0] add;
  logic [SPEED_W:0] acc_sum;
  logic [PROD_W-1:0] rem_x_up;
  logic [PROD_W-1:0] acc_x_dn;
  logic decel_due;
  logic tri_due;
  logic last_pulse;

  // ---------------------------------------------------------------
  // multiplier and rate dividers
  // ---------------------------------------------------------------
  // one base tick every mult_code+1 clocks sets the pulse rate per speed unit
  always_ff @(posedge clk) begin
    if (reset || base_cnt_q >= mult_code_q) begin
      base_cnt_q <= '0;
    end else begin
      base_cnt_q <= base_cnt_q + 1'b1;
    end
  end
  assign base_tick = (base_cnt_q >= mult_code_q);

  // ramp steps come every up_rate+1 or down_rate+1 base ticks
  always_ff @(posedge clk) begin
    if (reset || state_q == ST_IDLE || (base_tick && step_tick)) begin
      rate_cnt_q <= '0;
    end else if (base_tick) begin
      rate_cnt_q <= rate_cnt_q + 1'b1;
    end
  end
  assign step_tick = (rate_cnt_q >= ((state_q == ST_DECEL) ? down_rate_q : up_rate_q));

  // ---------------------------------------------------------------
  // band and step arithmetic
  // ---------------------------------------------------------------
  assign feed_eff = (feed_speed_q > FEED_MAX) ? FEED_MAX : feed_speed_q;
  assign band_up = band_of(accel_span_q, applied_top_q, start_speed_q,
                           ramp_shape_select_q);
  assign band_dn = band_of(decel_span_q, applied_top_q, start_speed_q,
                           ramp_shape_select_q);
  assign band = (state_q == ST_DECEL) ? band_dn : band_up;

  // distance from each end of the ramp picks s weight or full linear weight
  assign add = step_add((speed_q > start_speed_q) ? speed_q - start_speed_q : '0,
                        (applied_top_q > speed_q) ? applied_top_q - speed_q : '0,
                        band);
  assign acc_sum = step_acc_q + {1'b0, add};

  // deceleration starts once the remaining pulses fall to the mirrored climb
  assign rem_x_up = PROD_W'(remaining_q) * PROD_W'({1'b0, up_rate_q} + 17'h00001);
  assign acc_x_dn = PROD_W'(accel_pulses_q) * PROD_W'({1'b0, down_rate_q} + 17'h00001);
  assign decel_due = (rem_x_up <= acc_x_dn);
  // remaining down to twice the mirrored climb: cap the top here and keep a flat part
  assign tri_due = (rem_x_up <= (acc_x_dn << 1)) && !auto_top_speed_correction_off_q;
  assign last_pulse = pulse_raw && (remaining_q == {{(AMT_W-1){1'b0}}, 1'b1});
  assign running = (state_q != ST_IDLE);

  // ---------------------------------------------------------------
  // motion sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      speed_q <= '0;
      applied_top_q <= '0;
      remaining_q <= '0;
      accel_pulses_q <= '0;
      corr_cnt_q <= '0;
      pending_move_q <= 1'b0;
      last_dir_q <= 1'b0;
      dir_out <= 1'b0;
      step_acc_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          step_acc_q <= '0;
          accel_pulses_q <= '0;
          applied_top_q <= top_speed_q;
          if (cmd_start && amount_q != '0) begin
            dir_out <= cmd_dir;
            remaining_q <= amount_q;
            speed_q <= start_speed_q;
            // a reversal with backlash set runs the correction first
            if (backlash_q != '0 && cmd_dir != last_dir_q) begin
              corr_cnt_q <= backlash_q;
              pending_move_q <= 1'b1;
              speed_q <= feed_eff;
              state_q <= ST_CORRECT;
            end else begin
              state_q <= ST_ACCEL;
            end
          end else if (cmd_corr && backlash_q != '0) begin
            dir_out <= cmd_dir;
            corr_cnt_q <= backlash_q;
            pending_move_q <= 1'b0;
            speed_q <= feed_eff;
            state_q <= ST_CORRECT;
          end else if (cmd_origin) begin
            dir_out <= ~last_dir_q;
            speed_q <= feed_eff;
            state_q <= ST_REVERSE;
          end
        end
        ST_CORRECT: begin
          speed_q <= feed_eff;
          if (cmd_stop) begin
            state_q <= ST_IDLE;
          end else if (pulse_raw && corr_cnt_q == {{(SPAN_W-1){1'b0}}, 1'b1}) begin
            last_dir_q <= dir_out;
            speed_q <= start_speed_q;
            state_q <= pending_move_q ? ST_ACCEL : ST_IDLE;
          end else if (pulse_raw) begin
            corr_cnt_q <= corr_cnt_q - 1'b1;
          end
        end
        ST_REVERSE: begin
          speed_q <= feed_eff;
          if (origin_sensor || cmd_stop) begin
            last_dir_q <= dir_out;
            state_q <= ST_IDLE;
          end
        end
        ST_ACCEL: begin
          if (pulse_raw) begin
            remaining_q <= remaining_q - 1'b1;
            accel_pulses_q <= accel_pulses_q + 1'b1;
          end
          if (last_pulse) begin
            last_dir_q <= dir_out;
            state_q <= ST_IDLE;
          end else if (cmd_stop || decel_due) begin
            step_acc_q <= '0;
            // with the correction off the written top stands; only the ramp turns over
            if (!auto_top_speed_correction_off_q) begin
              applied_top_q <= speed_q;
            end
            state_q <= ST_DECEL;
          end else if (tri_due) begin
            applied_top_q <= speed_q;
            state_q <= ST_CONST;
          end else if (speed_q >= applied_top_q) begin
            speed_q <= applied_top_q;
            state_q <= ST_CONST;
          end else if (base_tick && step_tick) begin
            if (acc_sum >= {1'b0, band}) begin
              step_acc_q <= acc_sum - {1'b0, band};
              speed_q <= speed_q + 1'b1;
            end else begin
              step_acc_q <= acc_sum;
            end
          end
        end
        ST_CONST: begin
          if (pulse_raw) begin
            remaining_q <= remaining_q - 1'b1;
          end
          if (last_pulse) begin
            last_dir_q <= dir_out;
            state_q <= ST_IDLE;
          end else if (cmd_stop || decel_due) begin
            step_acc_q <= '0;
            state_q <= ST_DECEL;
          end
        end
        ST_DECEL: begin
          if (pulse_raw) begin
            remaining_q <= remaining_q - 1'b1;
          end
          if (last_pulse || (cmd_stop && speed_q <= start_speed_q)) begin
            last_dir_q <= dir_out;
            state_q <= ST_IDLE;
          end else if (speed_q > start_speed_q && base_tick && step_tick) begin
            if (acc_sum >= {1'b0, band}) begin
              step_acc_q <= acc_sum - {1'b0, band};
              speed_q <= speed_q - 1'b1;
            end else begin
              step_acc_q <= acc_sum;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pulse output
  // ---------------------------------------------------------------
  scrcs_pulse_gen #(
    .ACC_W(ACC_W)
  ) u_pulse (
    .clk(clk),
    .reset(reset),
    .en(base_tick),
    .run(running),
    .speed(speed_q),
    .pulse(pulse_raw)
  );

  // re-registered so the pins come straight off flip-flops
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_out <= 1'b0;
      busy <= 1'b0;
    end else begin
      pulse_out <= pulse_raw;
      busy <= running;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        OFS_ACCEL_SPAN: reg_rdata <= DATA_W'(accel_span_q);
        OFS_DECEL_SPAN: reg_rdata <= DATA_W'(decel_span_q);
        OFS_FEED_SPEED: reg_rdata <= DATA_W'(feed_speed_q);
        OFS_TOP_SPEED: reg_rdata <= DATA_W'(top_speed_q);
        OFS_START_SPEED: reg_rdata <= DATA_W'(start_speed_q);
        OFS_UP_RATE: reg_rdata <= DATA_W'(up_rate_q);
        OFS_DOWN_RATE: reg_rdata <= DATA_W'(down_rate_q);
        OFS_MULT_CODE: reg_rdata <= DATA_W'(mult_code_q);
        OFS_AMOUNT: reg_rdata <= DATA_W'(amount_q);
        OFS_MODE: reg_rdata <= DATA_W'({auto_top_speed_correction_off_q, ramp_shape_select_q});
        OFS_BACKLASH: reg_rdata <= DATA_W'(backlash_q);
        OFS_STATUS: reg_rdata <= DATA_W'({last_dir_q, dir_out, running, state_q});
        OFS_CUR_SPEED: reg_rdata <= DATA_W'(speed_q);
        OFS_REMAINING: reg_rdata <= DATA_W'(remaining_q);
        OFS_APPLIED_TOP: reg_rdata <= DATA_W'(applied_top_q);
        default: reg_rdata <= '0;
      endcase
    end
  end

endmodule

/* scrcs_axis_profile_checker.sv */
// port-level assertions for the axis speed profile block
// assumes one clock domain and the strobe register port of the block
`timescale 1ns/10ps
module scrcs_axis_profile_checker
  import scrcs_pkg::*;
#(
  parameter int unsigned ACC_W = 18
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [scrcs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [scrcs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [scrcs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic origin_sensor,
  input wire logic pulse_out,
  input wire logic dir_out,
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside read answer cycle");
  a_cmd_reads_zero: assert property (reg_rd && reg_addr == OFS_COMMAND |=> reg_rdata == '0)
    else $error("command index read back nonzero");
  a_unmapped_zero: assert property (reg_rd && reg_addr > OFS_APPLIED_TOP |=> reg_rdata == '0)
    else $error("unmapped index read back nonzero");
  a_reset_quiet: assert property ($past(reset) |-> !busy && !pulse_out && !dir_out)
    else $error("outputs not quiet right after reset");
  a_pulse_single: assert property (pulse_out |=> !pulse_out)
    else $error("output pulse longer than one cycle");
  a_pulse_busy: assert property (pulse_out |-> busy || $past(busy))
    else $error("pulse issued while axis idle");
  a_dir_hold: assert property (busy && $past(busy) |-> $stable(dir_out))
    else $error("direction changed during motion");
  a_busy_cause: assert property ($rose(busy) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == OFS_COMMAND)
    else $error("busy rose without a command write");
endmodule

bind scrcs_axis_profile scrcs_axis_profile_checker #(.ACC_W(ACC_W)) i_chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .origin_sensor(origin_sensor),
  .pulse_out(pulse_out), .dir_out(dir_out), .busy(busy)
);

/* scrcs_driver_model.sv */
// motor driver stand-in: counts pulses, tracks position, measures pulse spacing
// assumes one pulse is one registered high cycle on step
`timescale 1ns/10ps
module scrcs_driver_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic step,
  input wire logic dir,
  output int steps,
  output int gap_min,
  output int gap_max,
  output int pos
);
  int since;
  always @(posedge clk) begin
    if (clr) begin
      steps <= 0;
      gap_min <= 1000000;
      gap_max <= 0;
      since <= 0;
    end else if (step) begin
      steps <= steps + 1;
      pos <= dir ? pos - 1 : pos + 1;
      since <= 0;
      // the first pulse has no predecessor, so it gives no spacing
      if (steps > 0) begin
        gap_min <= (since + 1 < gap_min) ? since + 1 : gap_min;
        gap_max <= (since + 1 > gap_max) ? since + 1 : gap_max;
      end
    end else begin
      since <= since + 1;
    end
  end
endmodule

/* scurve_range_and_correction_speed_tb_top.sv */
// self-checking bench: register model, correction and reversal rates, short moves
// assumes the bound checker and the driver model are compiled alongside
`timescale 1ns/10ps
module scurve_range_and_correction_speed_tb_top;
  import scrcs_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic origin_sensor = 1'b0;
  logic origin_arm = 1'b0;
  logic pulse_out;
  logic dir_out;
  logic busy;
  logic clr = 1'b0;
  int steps;
  int gap_min;
  int gap_max;
  int error_cnt = 0;
  int checks = 0;
  logic [31:0] seed = 32'h2921;
  logic [DATA_W-1:0] model_q [16];
  logic [DATA_W-1:0] got;
  logic [DATA_W-1:0] top_min;

  always #50 clk = ~clk;

  scrcs_axis_profile #(.ACC_W(18)) i_dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .origin_sensor(origin_sensor),
    .pulse_out(pulse_out), .dir_out(dir_out), .busy(busy)
  );
  scrcs_driver_model i_drv (
    .clk(clk), .clr(clr), .step(pulse_out), .dir(dir_out), .steps(steps),
    .gap_min(gap_min), .gap_max(gap_max), .pos()
  );

  // home switch closes once the reversal has made three pulses
  always @(posedge clk) begin
    origin_sensor <= origin_arm && busy && steps >= 3;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction

  function automatic logic [DATA_W-1:0] wmask(input int idx);
    case (idx)
      0, 1, 5, 6, 10: wmask = 32'h0000_ffff;
      2, 3, 4: wmask = 32'h0001_ffff;
      7: wmask = 32'h0000_0fff;
      8: wmask = 32'h00ff_ffff;
      9: wmask = 32'h0000_0003;
      default: wmask = '0;
    endcase
  endfunction

  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic wr(input int idx, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= idx[ADDR_W-1:0];
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (idx < 16) model_q[idx] = d & wmask(idx);
  endtask

  task automatic rd(input int idx, output logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= idx[ADDR_W-1:0];
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask

  task automatic rd_chk(input int idx);
    logic [DATA_W-1:0] e;
    e = (idx < 16) ? model_q[idx] : '0;
    rd(idx, got);
    chk(got === e, "register readback");
  endtask

  task automatic run_cmd(input logic [DATA_W-1:0] c);
    int n;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wr(11, c);
    repeat (4) @(posedge clk);
    n = 0;
    top_min = '1;
    // applied top is reloaded once idle, so it is watched while the axis runs
    while (busy !== 1'b0 && n < 20000) begin
      rd(15, got);
      if (got < top_min) top_min = got;
      n++;
    end
    chk(n < 20000, "operation did not finish");
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 16; i++) model_q[i] = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) rd_chk(i);
    wr(31, 32'hffff_ffff);
    rd_chk(31);
    // raw values stay stored; clamping happens only where they are used
    wr(0, 32'hffff_ffff);
    rd_chk(0);
    wr(1, 32'h0000_c351);
    rd_chk(1);
    wr(2, 32'h0001_ffff);
    rd_chk(2);
    for (int i = 0; i < 11; i++) begin
      seed = xs(seed);
      wr(i, seed);
      rd_chk(i);
    end
    wr(7, 32'h0000_0000);
    wr(9, 32'h0000_0000);
    wr(10, 32'h0000_0008);
    wr(2, 32'h0001_ffff);
    run_cmd(32'h0000_0004);
    chk(steps == 8, "correction pulse count");
    chk(gap_min == 2 && gap_max == 3, "feed speed not limited");
    wr(2, 32'h0000_4000);
    run_cmd(32'h0000_0004);
    chk(steps == 8 && gap_min == 16 && gap_max == 16, "correction rate");
    wr(10, 32'h0000_0000);
    origin_arm <= 1'b1;
    run_cmd(32'h0000_0008);
    chk(steps >= 3 && gap_min == 16 && gap_max == 16, "reversal rate");
    chk(dir_out === 1'b1, "reversal direction");
    origin_arm <= 1'b0;
    wr(3, 32'h0001_0000);
    wr(4, 32'h0000_2000);
    wr(5, 32'h0000_0000);
    wr(6, 32'h0000_0000);
    wr(0, 32'h0000_0000);
    wr(1, 32'h0000_0000);
    wr(8, 32'h0000_000a);
    // every shape and top-speed-correction combination on a move too short to reach top
    for (int m = 0; m < 4; m++) begin
      wr(9, m);
      run_cmd(32'h0000_0001);
      chk(steps == 10, "move length");
      if (m[1]) chk(top_min === 32'h0001_0000, "top speed altered");
      else chk(top_min < 32'h0001_0000, "top speed not lowered");
    end
    // a reversed start with backlash set runs the correction ahead of the move
    wr(10, 32'h0000_0004);
    run_cmd(32'h0000_0003);
    chk(steps == 14, "correction before reversed move");
    chk(top_min === 32'h0001_0000, "top speed altered on reversed move");
    print_verdict();
  end

  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule
